/* File: hw/uvs_supervisor.sv */
// output undervoltage supervisor: thresholds, status and fault response
module uvs_supervisor import uvs_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // command port
  input wire logic cmd_wr_en,
  input wire logic cmd_rd_en,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_reject,
  // configuration from the rest of the controller
  input wire logic [15:0] output_voltage_setpoint,
  input wire logic voltage_format_select,
  input wire logic [15:0] soft_start_ramp_time,
  input wire logic [15:0] nvm_warn,
  input wire logic [15:0] nvm_fault,
  input wire logic [7:0] nvm_action,
  // converter
  input wire logic power_on_cmd,
  input wire logic pwm_tick,
  input wire logic [15:0] vout_sense,
  output logic conv_enable,
  // status
  input wire logic clear_status,
  output logic [7:0] status_byte,
  output logic [15:0] status_word,
  output logic [7:0] status_vout,
  output logic [7:0] status_cml,
  output logic alert_n
);
  // stored commands and their hardware steps
  logic [15:0] warn_q;
  logic [15:0] fault_q;
  logic [7:0] action_q;
  logic [3:0] warn_code_q;
  logic [3:0] fault_code_q;
  logic init_q; // one cycle after reset: load stored values
  // response machine
  uvs_state_t st_q, st_d;
  logic [19:0] cnt_q, cnt_d;
  logic [2:0] retries_q, retries_d;
  logic conv_enable_q;
  // status flags
  logic warn_flag_q;
  logic fault_flag_q;
  logic cml_flag_q;
  logic alert_q;
  // command port answers
  logic [15:0] rdata_q;
  logic ack_q;
  logic reject_q;

  // write source: stored values on the first cycle, host afterwards
  logic hit_warn, hit_fault, hit_act;
  logic [15:0] warn_src, fault_src;
  logic [7:0] act_src;
  assign hit_warn = init_q | (cmd_wr_en && cmd_code == CMD_WARN);
  assign hit_fault = init_q | (cmd_wr_en && cmd_code == CMD_FAULT);
  assign hit_act = init_q | (cmd_wr_en && cmd_code == CMD_ACTION);
  assign warn_src = init_q ? nvm_warn : cmd_wdata;
  assign fault_src = init_q ? nvm_fault : cmd_wdata;
  // byte command: only the low byte is taken
  assign act_src = init_q ? nvm_action : cmd_wdata[7:0];

  // conversion of written values to steps
  logic [3:0] warn_code_w, fault_code_w;
  logic warn_ok, fault_ok, act_ok;
  uvs_pct_conv #(.LO(WARN_LO), .HI(WARN_HI), .STEP(WARN_STEP)) u_warn_conv (
    .raw(warn_src),
    .setpoint(output_voltage_setpoint),
    .relative(voltage_format_select),
    .code(warn_code_w),
    .valid(warn_ok)
  );
  // the fault limit is always read in the absolute sense
  uvs_pct_conv #(.LO(FAULT_LO), .HI(FAULT_HI), .STEP(FAULT_STEP)) u_fault_conv (
    .raw(fault_src),
    .setpoint(output_voltage_setpoint),
    .relative(1'b0),
    .code(fault_code_w),
    .valid(fault_ok)
  );
  assign act_ok = act_src[ACT_RESP_HI:ACT_RESP_LO] != RESP_INVALID;

  logic wr_bad, wr_good;
  assign wr_bad = (hit_warn && !warn_ok) || (hit_fault && !fault_ok) || (hit_act && !act_ok);
  assign wr_good = !init_q && cmd_wr_en && !wr_bad && (hit_warn || hit_fault || hit_act);

  // updated only on the load or an accepted write; the step holds while the setpoint changes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      warn_q <= RST_THRESH;
      warn_code_q <= RST_CODE;
    end else if (hit_warn && warn_ok) begin
      warn_q <= warn_src;
      warn_code_q <= warn_code_w;
    end
  end

  // setpoint enters only through the converter at a load or write, so absolute values hold on its change
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= RST_THRESH;
      fault_code_q <= RST_CODE;
    end else if (hit_fault && fault_ok) begin
      fault_q <= fault_src;
      fault_code_q <= fault_code_w;
    end
  end

  // fault action register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      action_q <= RST_ACTION;
    end else if (hit_act && act_ok) begin
      action_q <= act_src;
    end
  end

  // stored values load once, just after reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // read mux; unknown codes read as zero
  logic [15:0] rd_mux;
  assign rd_mux = (cmd_code == CMD_WARN) ? warn_q :
                  (cmd_code == CMD_FAULT) ? fault_q :
                  (cmd_code == CMD_ACTION) ? {8'h00, action_q} : 16'h0000;

  // one-cycle answers for reads and writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      if (cmd_rd_en) begin
        rdata_q <= rd_mux;
      end
      ack_q <= wr_good || (cmd_rd_en && !cmd_wr_en);
      reject_q <= wr_bad && !init_q;
    end
  end

  // threshold comparators
  logic [9:0] warn_pct, fault_pct;
  logic warn_below, fault_below;
  assign warn_pct = WARN_LO_P + 10'(warn_code_q) * WARN_STEP_P;
  assign fault_pct = FAULT_LO_P + 10'(fault_code_q) * FAULT_STEP_P;
  uvs_thr_cmp u_warn_cmp (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sense(vout_sense),
    .setpoint(output_voltage_setpoint),
    .pct(warn_pct),
    .below(warn_below)
  );
  uvs_thr_cmp u_fault_cmp (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sense(vout_sense),
    .setpoint(output_voltage_setpoint),
    .pct(fault_pct),
    .below(fault_below)
  );

  // fields of the action byte
  logic [1:0] resp;
  logic [2:0] restart;
  logic [2:0] dly;
  assign resp = action_q[ACT_RESP_HI:ACT_RESP_LO];
  assign restart = action_q[ACT_RETRY_HI:ACT_RETRY_LO];
  assign dly = action_q[ACT_DLY_HI:0];

  // monitoring is off while ramping: the output is still rising
  logic mon, warn_hit, fault_hit;
  assign mon = (st_q == ST_RUN) || (st_q == ST_DELAY) || (st_q == ST_CONFIRM);
  assign warn_hit = mon && warn_below;
  assign fault_hit = mon && fault_below;

  // delay and hiccup lengths from the delay code
  logic [19:0] dly_len, hiccup_len, ramp_len;
  logic [2:0] mult;
  assign dly_len = (dly <= 3'h1) ? DLY_SHORT : (dly <= 3'h4) ? DLY_MID : DLY_LONG;
  assign mult = (dly == 3'h0) ? 3'h1 : dly;
  // widened before the product so a long ramp time cannot wrap
  assign hiccup_len = 20'(mult) * ramp_len;
  assign ramp_len = {4'h0, soft_start_ramp_time};

  // retry decision on each shutdown
  logic go_hiccup;
  assign go_hiccup = (restart != RETRY_NONE) &&
                     (restart == RETRY_ENDLESS || retries_q < restart);

  // next state of the response machine
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != 20'h00000) ? cnt_q - 20'h00001 : cnt_q;
    retries_d = retries_q;
    case (st_q)
      ST_OFF: begin
        if (power_on_cmd) begin
          st_d = ST_RAMP;
          cnt_d = ramp_len;
          retries_d = 3'h0;
        end
      end
      ST_RAMP, ST_HICCUP: begin
        if (!power_on_cmd) begin
          st_d = ST_OFF;
        end else if (cnt_q <= 20'h00001) begin
          st_d = (st_q == ST_RAMP) ? ST_CONFIRM : ST_RAMP;
          cnt_d = ramp_len;
        end
      end
      ST_RUN, ST_CONFIRM, ST_DELAY: begin
        if (!power_on_cmd) begin
          st_d = ST_OFF;
        end else if ((st_q == ST_DELAY && fault_below && pwm_tick && cnt_q <= 20'h00001) ||
                     (st_q != ST_DELAY && fault_hit && resp == RESP_IMMED)) begin
          st_d = go_hiccup ? ST_HICCUP : ST_LATCH;
          cnt_d = hiccup_len;
          if (go_hiccup && restart != RETRY_ENDLESS) begin
            retries_d = retries_q + 3'h1;
          end
        end else if (st_q == ST_DELAY) begin
          // fault gone before the delay ran out: keep converting
          if (!fault_below) begin
            st_d = ST_RUN;
          end
          cnt_d = pwm_tick ? cnt_q - 20'h00001 : cnt_q;
        end else if (fault_hit && resp == RESP_DELAYED) begin
          st_d = ST_DELAY;
          cnt_d = dly_len;
        end else if (st_q == ST_CONFIRM && cnt_q <= 20'h00001) begin
          st_d = ST_RUN;
          retries_d = 3'h0;
        end
      end
      ST_LATCH: begin
        // only a command off releases a latched shutdown
        if (!power_on_cmd) begin
          st_d = ST_OFF;
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
  end

  // response machine registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_OFF;
      cnt_q <= 20'h00000;
      retries_q <= 3'h0;
      conv_enable_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      retries_q <= retries_d;
      conv_enable_q <= (st_d == ST_RAMP) || (st_d == ST_CONFIRM) ||
                       (st_d == ST_RUN) || (st_d == ST_DELAY);
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      warn_flag_q <= 1'b0;
      fault_flag_q <= 1'b0;
      cml_flag_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      warn_flag_q <= warn_hit || (warn_flag_q && !clear_status);
      fault_flag_q <= fault_hit || (fault_flag_q && !clear_status);
      cml_flag_q <= (wr_bad && !init_q) || (cml_flag_q && !clear_status);
      alert_q <= warn_hit || fault_hit || (wr_bad && !init_q) ||
                 ((warn_flag_q || fault_flag_q || cml_flag_q) && !clear_status);
    end
  end

  // status layout
  assign status_vout = 8'(({7'h00, warn_flag_q} << SV_UV_WARN) |
                          ({7'h00, fault_flag_q} << SV_UV_FAULT));
  assign status_cml = 8'({7'h00, cml_flag_q} << SC_BAD_DATA);
  assign status_byte = 8'(({7'h00, fault_flag_q} << SB_NOTA) |
                          ({7'h00, cml_flag_q} << SB_CML));
  assign status_word = 16'(({15'h0000, warn_flag_q || fault_flag_q} << SW_VOUT) |
                           {8'h00, status_byte});
  assign alert_n = !alert_q;
  assign conv_enable = conv_enable_q;
  assign cmd_rdata = rdata_q;
  assign cmd_ack = ack_q;
  assign cmd_reject = reject_q;

  // checks
  a_warn_flag_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    warn_hit |=> warn_flag_q && status_word[SW_VOUT] && !alert_n)
    else $error("warning crossing did not raise flags");
  a_fault_flag_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    fault_hit |=> fault_flag_q && status_byte[SB_NOTA] && status_vout[SV_UV_FAULT])
    else $error("fault did not raise flags");
  a_bad_action_kept: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!init_q && cmd_wr_en && cmd_code == CMD_ACTION && cmd_wdata[7:6] == RESP_INVALID)
    |=> cmd_reject && status_cml[SC_BAD_DATA] && $stable(action_q))
    else $error("invalid action byte not rejected");
  a_immed_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == ST_RUN && power_on_cmd && fault_hit && resp == RESP_IMMED) |=> !conv_enable)
    else $error("immediate response kept converting");
  a_ignore_runs: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == ST_RUN && power_on_cmd && resp == RESP_IGNORE) |=> st_q == ST_RUN && conv_enable)
    else $error("ignore response stopped conversion");
  a_latch_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == ST_RUN && power_on_cmd && fault_hit && resp == RESP_IMMED && restart == 3'h0)
    |=> st_q == ST_LATCH ##1 (st_q == ST_LATCH || !$past(power_on_cmd)))
    else $error("zero restart count did not latch off");
  a_abs_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!voltage_format_select && !init_q && !cmd_wr_en && $changed(output_voltage_setpoint))
    |=> $stable(warn_code_q) && $stable(fault_code_q) && $stable(fault_q) && $stable(warn_q))
    else $error("setpoint change moved stored thresholds");
  a_confirm_ok: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == ST_CONFIRM && power_on_cmd && !fault_hit && cnt_q <= 20'h00001)
    |=> st_q == ST_RUN && retries_q == 3'h0)
    else $error("successful restart did not clear retries");
  a_short_delay: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == ST_RUN && power_on_cmd && fault_hit && resp == RESP_DELAYED && dly <= 3'h1)
    |=> st_q == ST_DELAY && cnt_q == DLY_SHORT)
    else $error("short delay code gave wrong delay");
  a_step_range: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !init_q |-> warn_code_q <= 4'hD && fault_code_q <= 4'hE)
    else $error("threshold step out of supported range");
endmodule : uvs_supervisor

/* File: hw/uvs_pkg.sv */
// constants shared by the output undervoltage supervisor
package uvs_pkg;
  // command codes
  localparam logic [7:0] CMD_WARN = 8'h43;
  localparam logic [7:0] CMD_FAULT = 8'h44;
  localparam logic [7:0] CMD_ACTION = 8'h45;
  // percentages are held in units of 0.1 percent
  localparam int unsigned WARN_LO = 840;
  localparam int unsigned WARN_HI = 970;
  localparam int unsigned WARN_STEP = 10;
  localparam int unsigned FAULT_LO = 600;
  localparam int unsigned FAULT_HI = 950;
  localparam int unsigned FAULT_STEP = 25;
  localparam logic [9:0] WARN_LO_P = 10'h348;
  localparam logic [9:0] WARN_STEP_P = 10'h00A;
  localparam logic [9:0] FAULT_LO_P = 10'h258;
  localparam logic [9:0] FAULT_STEP_P = 10'h019;
  localparam logic [25:0] PCT_SCALE = 26'h3E8;
  // fault action fields
  localparam int unsigned ACT_RESP_HI = 7;
  localparam int unsigned ACT_RESP_LO = 6;
  localparam int unsigned ACT_RETRY_HI = 5;
  localparam int unsigned ACT_RETRY_LO = 3;
  localparam int unsigned ACT_DLY_HI = 2;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_IMMED = 2'h2;
  localparam logic [1:0] RESP_INVALID = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;
  // shutdown delays in switching cycles
  localparam logic [19:0] DLY_SHORT = 20'h00001;
  localparam logic [19:0] DLY_MID = 20'h00003;
  localparam logic [19:0] DLY_LONG = 20'h00007;
  // status bit positions
  localparam int unsigned SB_NOTA = 0;
  localparam int unsigned SB_CML = 1;
  localparam int unsigned SW_VOUT = 15;
  localparam int unsigned SV_UV_WARN = 5;
  localparam int unsigned SV_UV_FAULT = 4;
  localparam int unsigned SC_BAD_DATA = 6;
  // values after reset, before the stored values load
  localparam logic [15:0] RST_THRESH = 16'h0000;
  localparam logic [7:0] RST_ACTION = 8'h00;
  localparam logic [3:0] RST_CODE = 4'h0;
  // fault response states
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_RAMP = 7'h02,
    ST_CONFIRM = 7'h04,
    ST_RUN = 7'h08,
    ST_DELAY = 7'h10,
    ST_HICCUP = 7'h20,
    ST_LATCH = 7'h40
  } uvs_state_t;
endpackage : uvs_pkg

/* File: hw/uvs_pct_conv.sv */
// maps a written threshold to a supported hardware percentage step
module uvs_pct_conv import uvs_pkg::*; #(
  parameter int unsigned LO = 840,
  parameter int unsigned HI = 970,
  parameter int unsigned STEP = 10
) (
  // value and reference
  input wire logic [15:0] raw,
  input wire logic [15:0] setpoint,
  input wire logic relative,
  // result
  output logic [3:0] code,
  output logic valid
);
  // absolute volts become a fraction of the present setpoint
  logic [25:0] abs_p;
  logic [25:0] pct;
  logic [25:0] idx;
  assign abs_p = (setpoint == 16'h0000) ? '1 : (raw * PCT_SCALE) / {10'h000, setpoint};
  assign pct = relative ? {10'h000, raw} : abs_p;
  // out of range is refused rather than clamped
  assign valid = (pct >= 26'(LO)) && (pct <= 26'(HI));
  // integer divide drops the remainder, so odd values round down
  assign idx = (pct - 26'(LO)) / 26'(STEP);
  assign code = valid ? idx[3:0] : RST_CODE;
endmodule : uvs_pct_conv

/* File: hw/uvs_thr_cmp.sv */
// compares sensed voltage with a percentage of the setpoint
module uvs_thr_cmp import uvs_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // operands
  input wire logic [15:0] sense,
  input wire logic [15:0] setpoint,
  input wire logic [9:0] pct,
  // result
  output logic below
);
  // both sides scaled so no divider is needed
  logic [25:0] lhs;
  logic [25:0] rhs;
  logic below_q;
  assign lhs = 26'(sense) * PCT_SCALE;
  assign rhs = 26'(setpoint) * 26'(pct);
  // registered to keep the multiplier off the status path
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      below_q <= 1'b0;
    end else begin
      below_q <= lhs < rhs;
    end
  end
  assign below = below_q;
endmodule : uvs_thr_cmp

/* File: testbench/uvs_host_model.sv */
// behavioural host issuing configuration commands to the supervisor
module uvs_host_model (
  // clock
  input wire logic clk_sys,
  // command port towards the device
  output logic cmd_wr_en,
  output logic cmd_rd_en,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_reject
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port: strobes low from time zero
  initial begin
    cmd_wr_en = 1'b0;
    cmd_rd_en = 1'b0;
    cmd_code = 8'hFF;
    cmd_wdata = 16'hFFFF;
  end
  // one strobe carries a whole word, or a byte in [7:0] for the action code
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rdata, output logic ack, output logic rej);
    @(negedge clk_sys);
    cmd_wr_en = wr;
    cmd_rd_en = !wr;
    cmd_code = code;
    // a byte transfer leaves the upper lane undefined, so junk is put there
    cmd_wdata = (code == 8'h45) ? {~data[7:0], data[7:0]} : data;
    @(negedge clk_sys);
    cmd_wr_en = 1'b0;
    cmd_rd_en = 1'b0;
    // stale data never lingers on the released lines
    cmd_code = ~code;
    cmd_wdata = ~data;
    rdata = cmd_rdata;
    ack = cmd_ack;
    rej = cmd_reject;
  endtask : xfer
endmodule : uvs_host_model

/* File: testbench/tb_top.sv */
// self-checking bench for the output undervoltage supervisor
module tb_top import uvs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset and design signals
  logic clk_sys, arst_n, cmd_wr_en, cmd_rd_en, cmd_ack, cmd_reject;
  logic [7:0] cmd_code, status_byte, status_vout, status_cml;
  logic [15:0] cmd_wdata, cmd_rdata, setpoint, vout_sense, status_word;
  logic fmt, power_on_cmd, pwm_tick, conv_enable, clear_status, alert_n;
  logic [15:0] rv; // last read value
  logic ak, rj; // last answer
  logic [2:0] tick_cnt;
  int n_mismatch, num_checks, nrise, cyc_cnt;
  // refusal table: code, data, refused, value read back afterwards
  logic [7:0] t_c [9] = '{8'h43, 8'h43, 8'h43, 8'h44, 8'h44, 8'h45, 8'h45, 8'h43, 8'h44};
  logic [15:0] t_d [9] = '{16'h0347, 16'h03CA, 16'h03CB, 16'h0257, 16'h03B6, 16'h00C0,
                           16'h0000, 16'h0389, 16'h0320};
  logic t_r [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [15:0] t_b [9] = '{16'h0384, 16'h03CA, 16'h03CA, 16'h0320, 16'h03B6, 16'h0080,
                           16'h0000, 16'h0389, 16'h0320};
  // device under test, power-up values valid at a 1000 setpoint
  uvs_supervisor dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_wr_en(cmd_wr_en),
    .cmd_rd_en(cmd_rd_en), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_ack(cmd_ack), .cmd_reject(cmd_reject), .output_voltage_setpoint(setpoint),
    .voltage_format_select(fmt), .soft_start_ramp_time(16'h0004), .nvm_warn(16'h0384),
    .nvm_fault(16'h0320), .nvm_action(8'h80), .power_on_cmd(power_on_cmd),
    .pwm_tick(pwm_tick), .vout_sense(vout_sense), .conv_enable(conv_enable),
    .clear_status(clear_status), .status_byte(status_byte), .status_word(status_word),
    .status_vout(status_vout), .status_cml(status_cml), .alert_n(alert_n));
  // host on the command port
  uvs_host_model host_u (.clk_sys(clk_sys), .cmd_wr_en(cmd_wr_en), .cmd_rd_en(cmd_rd_en),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .cmd_reject(cmd_reject));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // switching tick every eight cycles, so a 7 tick delay spans 49 cycles or more
  always @(negedge clk_sys) begin
    tick_cnt <= tick_cnt + 3'h1;
    pwm_tick <= (tick_cnt == 3'h7);
  end
  // counts restarts of the converter
  always @(posedge conv_enable) nrise++;
  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(1'b1, c, d, rv, ak, rj);
  endtask : wr
  task automatic rd(input logic [7:0] c);
    host_u.xfer(1'b0, c, 16'h0000, rv, ak, rj);
  endtask : rd
  // sticky flags cleared by one pulse
  task automatic clr();
    @(negedge clk_sys);
    clear_status = 1'b1;
    @(negedge clk_sys);
    clear_status = 1'b0;
    cyc(3);
  endtask : clr
  // bounded wait for the converter enable to reach a level
  task automatic wait_en(input logic v);
    for (int i = 0; i < 300 && conv_enable !== v; i++) @(negedge clk_sys);
    chk("conv_enable", {15'h0000, conv_enable}, {15'h0000, v});
  endtask : wait_en
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    arst_n = 1'b0;
    setpoint = 16'h03E8;
    vout_sense = 16'h03E8;
    fmt = 1'b0;
    power_on_cmd = 1'b0;
    clear_status = 1'b0;
    pwm_tick = 1'b0;
    tick_cnt = 3'h0;
    cyc(16);
    arst_n = 1'b1;
    cyc(2);
    // power-up values come from storage
    rd(CMD_WARN);
    chk("warn", rv, 16'h0384);
    chk("rd_ack", {14'h0000, ak, rj}, 16'h0002);
    rd(CMD_FAULT);
    chk("fault", rv, 16'h0320);
    rd(CMD_ACTION);
    chk("action", rv, 16'h0080);
    chk("alert_n", {15'h0000, alert_n}, 16'h0001);
    // range edges, refused values leave the register alone
    for (int i = 0; i < 9; i++) begin
      wr(t_c[i], t_d[i]);
      chk("reject", {15'h0000, rj}, {15'h0000, t_r[i]});
      chk("ack", {15'h0000, ak}, {15'h0000, !t_r[i]});
      rd(t_c[i]);
      chk("readback", rv, t_b[i]);
    end
    chk("cml", {8'h00, status_cml}, 16'h0040);
    chk("byte_cml", {15'h0000, status_byte[1]}, 16'h0001);
    chk("alert_n", {15'h0000, alert_n}, 16'h0000);
    wr(8'h46, 16'h1234);
    chk("other_ack", {14'h0000, ak, rj}, 16'h0000);
    rd(8'h46);
    chk("other_rd", rv, 16'h0000);
    clr();
    chk("alert_n", {15'h0000, alert_n}, 16'h0001);
    // ignore response; warn 90.5 percent rounds down to 90
    power_on_cmd = 1'b1;
    cyc(20);
    chk("conv_enable", {15'h0000, conv_enable}, 16'h0001);
    vout_sense = 16'h0386;
    cyc(4);
    chk("warn_902", {8'h00, status_vout}, 16'h0000);
    vout_sense = 16'h0382;
    cyc(4);
    chk("warn_898", {8'h00, status_vout}, 16'h0020);
    chk("word", {status_word[15], 15'h0000}, 16'h8000);
    chk("alert_n", {15'h0000, alert_n}, 16'h0000);
    vout_sense = 16'h02BC;
    cyc(20);
    chk("ignore_en", {15'h0000, conv_enable}, 16'h0001);
    chk("fault_flags", {status_byte[0], status_vout[4], 14'h0000}, 16'hC000);
    vout_sense = 16'h03E8;
    clr();
    // immediate response, no retry: latched off
    wr(CMD_ACTION, 16'h0080);
    vout_sense = 16'h02BC;
    cyc(4);
    chk("immed_en", {15'h0000, conv_enable}, 16'h0000);
    cyc(100);
    chk("latch_en", {15'h0000, conv_enable}, 16'h0000);
    power_on_cmd = 1'b0;
    vout_sense = 16'h03E8;
    clr();
    power_on_cmd = 1'b1;
    cyc(20);
    // delayed response, one retry, success clears the count
    wr(CMD_ACTION, 16'h004F);
    nrise = 0;
    vout_sense = 16'h02BC;
    cyc(10);
    chk("delay_en", {15'h0000, conv_enable}, 16'h0001);
    wait_en(1'b0);
    vout_sense = 16'h03E8;
    wait_en(1'b1);
    cyc(20);
    vout_sense = 16'h02BC;
    wait_en(1'b0);
    cyc(300);
    chk("restarts", nrise[15:0], 16'h0002);
    chk("final_en", {15'h0000, conv_enable}, 16'h0000);
    // absolute thresholds survive a setpoint change
    power_on_cmd = 1'b0;
    vout_sense = 16'h07D0;
    setpoint = 16'h07D0;
    clr();
    rd(CMD_WARN);
    chk("warn_keep", rv, 16'h0389);
    rd(CMD_FAULT);
    chk("fault_keep", rv, 16'h0320);
    // relative warn 91.5 percent of 2000 rounds to 1820
    wr(CMD_FAULT, 16'h0640);
    fmt = 1'b1;
    wr(CMD_WARN, 16'h0393);
    chk("rel_ack", {15'h0000, ak}, 16'h0001);
    power_on_cmd = 1'b1;
    cyc(20);
    vout_sense = 16'h0721;
    cyc(4);
    chk("rel_1825", {8'h00, status_vout}, 16'h0000);
    vout_sense = 16'h0717;
    cyc(4);
    chk("rel_1815", {8'h00, status_vout}, 16'h0020);
    // delayed response, shortest delay, endless retries: more rises than any finite count
    wr(CMD_ACTION, 16'h0079);
    chk("endless_ack", {15'h0000, ak}, 16'h0001);
    nrise = 0;
    vout_sense = 16'h05DC;
    wait_en(1'b0);
    cyc(200);
    chk("endless", {15'h0000, nrise > 7}, 16'h0001);
    give_verdict();
  end
endmodule : tb_top
